//--- pkg/qsf_pkg.sv
// Shared constants and types for the quad soft-flow channel block.
// Assumes one core clock and an APB master with 8-bit byte addresses.
package qsf_pkg;

  localparam int NUM_CHAN = 4;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;

  // Byte address is channel in the top bits, then word index, then lanes.
  localparam int CHAN_LSB = 6;
  localparam int IDX_LSB  = 2;

  localparam logic [3:0] IDX_INT_EN     = 4'h0;
  localparam logic [3:0] IDX_INT_STAT   = 4'h1;
  localparam logic [3:0] IDX_LINE_CTL   = 4'h2;
  localparam logic [3:0] IDX_MODEM_CTL  = 4'h3;
  localparam logic [3:0] IDX_LINE_STAT  = 4'h4;
  localparam logic [3:0] IDX_MODEM_STAT = 4'h5;
  localparam logic [3:0] IDX_FIFO_CTL   = 4'h6;
  localparam logic [3:0] IDX_FEATURE    = 4'h7;
  localparam logic [3:0] IDX_H1   = 4'h8;
  localparam logic [3:0] IDX_H2   = 4'h9;
  localparam logic [3:0] IDX_R1   = 4'hA;
  localparam logic [3:0] IDX_R2   = 4'hB;
  localparam logic [3:0] IDX_CMD  = 4'hC;

  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_INT_STAT  = 8'h01;
  localparam logic [7:0] RST_LINE_STAT = 8'h60;
  localparam logic [3:0] RST_NIBBLE    = 4'h0;

  // Flow selection field positions inside the enhanced feature register.
  localparam int SEL_TX_FIRST  = 3;
  localparam int SEL_TX_SECOND = 2;
  localparam int SEL_RX_FIRST  = 1;
  localparam int SEL_RX_SECOND = 0;
  localparam int SEL_MSB       = 3;

  localparam int MODEM_CTL_DTR = 0;
  localparam int MODEM_CTL_RTS = 1;
  localparam int CMD_HALT  = 0;
  localparam int CMD_RESUME = 1;

  typedef struct packed {
    logic [7:0] halt_char_first;
    logic [7:0] halt_char_second;
    logic [7:0] resume_char_first;
    logic [7:0] resume_char_second;
  } qsf_chars_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } qsf_char_t;

endpackage : qsf_pkg

//--- logic/qsf_chan.sv
// One channel of soft flow control: sends halt/resume characters and
// watches received characters for the configured halt/resume codes.
// Assumes the transmitter takes a character when valid and ready meet.
`timescale 1ns/10ps
`default_nettype none
module qsf_chan (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [3:0]        sel,
  input  wire qsf_pkg::qsf_chars_t chars,
  input  wire logic              send_halt,
  input  wire logic              send_resume,
  input  wire logic              tx_ready,
  input  wire qsf_pkg::qsf_char_t rx_in,
  output qsf_pkg::qsf_char_t     tx_out,
  output logic                   rx_halted
);

  typedef enum logic [2:0] {
    QSF_IDLE   = 3'b001,
    QSF_FIRST  = 3'b010,
    QSF_SECOND = 3'b100
  } qsf_tx_state_t;

  qsf_tx_state_t state;
  logic [7:0]    second_char;
  logic          armed_halt;
  logic          armed_resume;

  wire use_first  = sel[qsf_pkg::SEL_TX_FIRST];
  wire use_second = sel[qsf_pkg::SEL_TX_SECOND];
  wire tx_both    = use_first & use_second;
  wire tx_on      = use_first | use_second;
  wire start      = (send_halt | send_resume) & tx_on;

  // pick sequence characters. Halt wins over resume when both ask.
  wire [7:0] load_first = send_halt ?
    (use_first ? chars.halt_char_first : chars.halt_char_second) :
    (use_first ? chars.resume_char_first : chars.resume_char_second);
  wire [7:0] load_second = send_halt ? chars.halt_char_second :
                                       chars.resume_char_second;

  wire rx_first  = sel[qsf_pkg::SEL_RX_FIRST];
  wire rx_second = sel[qsf_pkg::SEL_RX_SECOND];
  wire rx_both   = rx_first & rx_second;
  wire is_h1 = rx_in.data == chars.halt_char_first;
  wire is_h2 = rx_in.data == chars.halt_char_second;
  wire is_r1 = rx_in.data == chars.resume_char_first;
  wire is_r2 = rx_in.data == chars.resume_char_second;

  wire single_halt   = (rx_first & ~rx_second & is_h1) |
                       (rx_second & ~rx_first & is_h2);
  wire single_resume = (rx_first & ~rx_second & is_r1) |
                       (rx_second & ~rx_first & is_r2);
  wire seq_halt   = rx_both & armed_halt & is_h2;
  wire seq_resume = rx_both & armed_resume & is_r2;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= QSF_IDLE;
      tx_out      <= '0;
      second_char <= qsf_pkg::RST_ZERO;
    end else begin
      unique case (state)
        QSF_IDLE: begin
          if (start) begin
            state        <= QSF_FIRST;
            tx_out.valid <= 1'b1;
            tx_out.data  <= load_first;
            second_char  <= load_second;
          end
        end
        QSF_FIRST: begin
          if (tx_ready) begin
            if (tx_both) begin
              state       <= QSF_SECOND;
              tx_out.data <= second_char;
            end else begin
              state        <= QSF_IDLE;
              tx_out.valid <= 1'b0;
            end
          end
        end
        QSF_SECOND: begin
          if (tx_ready) begin
            state        <= QSF_IDLE;
            tx_out.valid <= 1'b0;
          end
        end
        default: begin
          state        <= QSF_IDLE;
          tx_out.valid <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_halted    <= 1'b0;
      armed_halt   <= 1'b0;
      armed_resume <= 1'b0;
    end else if (!(rx_first | rx_second)) begin
      rx_halted    <= 1'b0;
      armed_halt   <= 1'b0;
      armed_resume <= 1'b0;
    end else if (rx_in.valid) begin
      armed_halt   <= rx_both & is_h1;
      armed_resume <= rx_both & is_r1;
      if (single_halt | seq_halt) begin
        rx_halted <= 1'b1;
      end else if (single_resume | seq_resume) begin
        rx_halted <= 1'b0;
      end
    end
  end

endmodule : qsf_chan
`default_nettype wire

//--- logic/qsf_top.sv
// Four-channel register file with soft flow selection and reset state,
// reached over APB. Assumes the serial datapath sits outside and hands
// received characters in and takes flow characters out.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Upper select bits choose transmit pairs.
// - Lower select bits choose receive compare pair.
// - Both receive bits compare two-character sequences.
// - Reset clears control and feature registers.
// - Reset sets interrupt status to no-pending.
// - Reset sets transmitter empty line bits.
// - Reset clears modem levels and deltas; levels then follow pins.
// - Reset drives serial, modem, DMA pins.
module qsf_top #(
  parameter int NUM_CHAN = qsf_pkg::NUM_CHAN
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic [qsf_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [qsf_pkg::DATA_W-1:0]  pwdata,
  output logic      [qsf_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [NUM_CHAN-1:0][3:0]    modem_in,
  input  wire qsf_pkg::qsf_char_t [NUM_CHAN-1:0] rx_in,
  input  wire logic [NUM_CHAN-1:0]         tx_ready,
  output qsf_pkg::qsf_char_t [NUM_CHAN-1:0] tx_flow,
  output logic      [NUM_CHAN-1:0]         rx_halted,
  output logic      [NUM_CHAN-1:0]         serial_out,
  output logic      [NUM_CHAN-1:0]         request_to_send_n,
  output logic      [NUM_CHAN-1:0]         terminal_ready_n,
  output logic                             rx_dma_request_n,
  output logic                             tx_dma_request_n
);

  // Decoding is shared by the write strobes and the read mux.
  function automatic logic idx_known(input logic [3:0] idx);
    idx_known = idx <= qsf_pkg::IDX_CMD;
  endfunction : idx_known

  logic [NUM_CHAN-1:0][7:0] interrupt_enable_reg;
  logic [NUM_CHAN-1:0][7:0] interrupt_status_reg;
  logic [NUM_CHAN-1:0][7:0] line_control_reg;
  logic [NUM_CHAN-1:0][7:0] modem_control_reg;
  logic [NUM_CHAN-1:0][7:0] line_status_reg;
  logic [NUM_CHAN-1:0][3:0] modem_level;
  logic [NUM_CHAN-1:0][3:0] modem_delta;
  logic [NUM_CHAN-1:0][7:0] fifo_control_reg;
  logic [NUM_CHAN-1:0][7:0] enhanced_feature_reg;
  qsf_pkg::qsf_chars_t [NUM_CHAN-1:0] flow_chars;
  logic [NUM_CHAN-1:0][31:0] rd_val;
  qsf_pkg::qsf_char_t [NUM_CHAN-1:0] tx_flow_w;
  logic [NUM_CHAN-1:0]       rx_halted_w;

  wire [1:0] acc_chan = paddr[qsf_pkg::ADDR_W-1:qsf_pkg::CHAN_LSB];
  wire [3:0] acc_idx  = paddr[qsf_pkg::CHAN_LSB-1:qsf_pkg::IDX_LSB];
  wire       aligned  = paddr[qsf_pkg::IDX_LSB-1:0] == 2'h0;
  wire       acc      = psel & penable;
  // The first access cycle builds the answer; the second completes it.
  wire       answer   = acc & ~pready;
  wire       take     = acc & pready;
  wire       bad      = ~aligned | ~idx_known(acc_idx);
  wire       wr_take  = take & pwrite & ~bad;
  wire       rd_take  = take & ~pwrite & ~bad;
  wire [7:0] wbyte    = pwdata[7:0];

  // APB slave answer, one wait state on every access.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= answer;
      pslverr <= answer & bad;
      if (answer) begin
        prdata <= (pwrite | bad) ? '0 : rd_val[acc_chan];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_dma_request_n <= 1'b1;
      tx_dma_request_n <= 1'b0;
    end else begin
      rx_dma_request_n <= 1'b1;
      tx_dma_request_n <= 1'b0;
    end
  end

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    wire sel_me  = acc_chan == 2'(c);
    wire wr_me   = wr_take & sel_me;
    wire mstat_rd = rd_take & sel_me &
                    (acc_idx == qsf_pkg::IDX_MODEM_STAT);
    wire cmd_wr  = wr_me & (acc_idx == qsf_pkg::IDX_CMD);
    wire [3:0] modem_chg = modem_level[c] ^ modem_in[c];

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        interrupt_enable_reg[c] <= qsf_pkg::RST_ZERO;
        line_control_reg[c]     <= qsf_pkg::RST_ZERO;
        modem_control_reg[c]    <= qsf_pkg::RST_ZERO;
        fifo_control_reg[c]     <= qsf_pkg::RST_ZERO;
        enhanced_feature_reg[c] <= qsf_pkg::RST_ZERO;
        flow_chars[c]           <= '0;
      end else if (wr_me) begin
        unique case (acc_idx)
          qsf_pkg::IDX_INT_EN:    interrupt_enable_reg[c] <= wbyte;
          qsf_pkg::IDX_LINE_CTL:  line_control_reg[c]     <= wbyte;
          qsf_pkg::IDX_MODEM_CTL: modem_control_reg[c]    <= wbyte;
          qsf_pkg::IDX_FIFO_CTL:  fifo_control_reg[c]     <= wbyte;
          qsf_pkg::IDX_FEATURE:   enhanced_feature_reg[c] <= wbyte;
          qsf_pkg::IDX_H1:  flow_chars[c].halt_char_first    <= wbyte;
          qsf_pkg::IDX_H2:  flow_chars[c].halt_char_second   <= wbyte;
          qsf_pkg::IDX_R1:  flow_chars[c].resume_char_first  <= wbyte;
          qsf_pkg::IDX_R2:  flow_chars[c].resume_char_second <= wbyte;
          default: begin
          end
        endcase
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        interrupt_status_reg[c] <= qsf_pkg::RST_INT_STAT;
        line_status_reg[c]      <= qsf_pkg::RST_LINE_STAT;
      end else begin
        interrupt_status_reg[c] <= qsf_pkg::RST_INT_STAT;
        line_status_reg[c]      <= qsf_pkg::RST_LINE_STAT;
      end
    end

    // levels track pins; a change beats a clearing read.
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        modem_level[c] <= qsf_pkg::RST_NIBBLE;
        modem_delta[c] <= qsf_pkg::RST_NIBBLE;
      end else begin
        modem_level[c] <= modem_in[c];
        modem_delta[c] <= (modem_delta[c] & {4{~mstat_rd}}) | modem_chg;
      end
    end

    // serial and modem pins after reset.
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        serial_out[c]        <= 1'b1;
        request_to_send_n[c] <= 1'b1;
        terminal_ready_n[c]  <= 1'b1;
        tx_flow[c]           <= '0;
        rx_halted[c]         <= 1'b0;
      end else begin
        serial_out[c]        <= 1'b1;
        request_to_send_n[c] <=
          ~modem_control_reg[c][qsf_pkg::MODEM_CTL_RTS];
        terminal_ready_n[c]  <=
          ~modem_control_reg[c][qsf_pkg::MODEM_CTL_DTR];
        tx_flow[c]           <= tx_flow_w[c];
        rx_halted[c]         <= rx_halted_w[c];
      end
    end

    assign rd_val[c] =
      (acc_idx == qsf_pkg::IDX_INT_EN) ? 32'(interrupt_enable_reg[c]) :
      (acc_idx == qsf_pkg::IDX_INT_STAT) ?
        32'(interrupt_status_reg[c]) :
      (acc_idx == qsf_pkg::IDX_LINE_CTL) ? 32'(line_control_reg[c]) :
      (acc_idx == qsf_pkg::IDX_MODEM_CTL) ? 32'(modem_control_reg[c]) :
      (acc_idx == qsf_pkg::IDX_LINE_STAT) ? 32'(line_status_reg[c]) :
      (acc_idx == qsf_pkg::IDX_MODEM_STAT) ?
        32'({modem_level[c], modem_delta[c]}) :
      (acc_idx == qsf_pkg::IDX_FIFO_CTL) ? 32'(fifo_control_reg[c]) :
      (acc_idx == qsf_pkg::IDX_FEATURE) ?
        32'(enhanced_feature_reg[c]) :
      (acc_idx == qsf_pkg::IDX_H1) ?
        32'(flow_chars[c].halt_char_first) :
      (acc_idx == qsf_pkg::IDX_H2) ?
        32'(flow_chars[c].halt_char_second) :
      (acc_idx == qsf_pkg::IDX_R1) ?
        32'(flow_chars[c].resume_char_first) :
      (acc_idx == qsf_pkg::IDX_R2) ?
        32'(flow_chars[c].resume_char_second) :
        32'({tx_flow_w[c].valid, rx_halted_w[c]});

    // configured codes treated as flow only.
    qsf_chan u_chan (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .sel         (enhanced_feature_reg[c][qsf_pkg::SEL_MSB:0]),
      .chars       (flow_chars[c]),
      .send_halt   (cmd_wr & pwdata[qsf_pkg::CMD_HALT]),
      .send_resume (cmd_wr & pwdata[qsf_pkg::CMD_RESUME]),
      .tx_ready    (tx_ready[c]),
      .rx_in       (rx_in[c]),
      .tx_out      (tx_flow_w[c]),
      .rx_halted   (rx_halted_w[c])
    );
  end

endmodule : qsf_top
`default_nettype wire

//--- sim/qsf_monitor.sv
// Checker on the top ports of the quad soft-flow block.
// Assumes one clock, an async active-low reset and a fixed APB wait.
`timescale 1ns/10ps
`default_nettype none
module qsf_monitor #(
  parameter int NUM_CHAN = 4
) (
  input wire logic                              mclk,
  input wire logic                              rst_n,
  input wire logic [7:0]                        paddr,
  input wire logic                              psel,
  input wire logic                              penable,
  input wire logic [31:0]                       prdata,
  input wire logic                              pready,
  input wire logic                              pslverr,
  input wire logic [NUM_CHAN-1:0]               tx_ready,
  input wire qsf_pkg::qsf_char_t [NUM_CHAN-1:0] rx_in,
  input wire qsf_pkg::qsf_char_t [NUM_CHAN-1:0] tx_flow,
  input wire logic [NUM_CHAN-1:0]               rx_halted,
  input wire logic [NUM_CHAN-1:0]               serial_out,
  input wire logic [NUM_CHAN-1:0]               request_to_send_n,
  input wire logic [NUM_CHAN-1:0]               terminal_ready_n,
  input wire logic                              rx_dma_request_n,
  input wire logic                              tx_dma_request_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  chk_apb_answer:
    assert property (s_setup |=> s_answer)
    else $error("answer not on second access cycle");
  chk_one_beat:
    assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_decode:
    assert property (pready |-> pslverr ==
      (paddr[1:0] != 2'h0 || paddr[5:2] > 4'hC))
    else $error("error flag wrong for address");
  chk_err_no_data:
    assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("data on refused access");
  chk_reset_pins:
    assert property ($rose(rst_n) |-> &request_to_send_n &&
      &terminal_ready_n && rx_halted == '0)
    else $error("pins not at reset level after reset");
  chk_line_idle:
    assert property (&serial_out && rx_dma_request_n && !tx_dma_request_n)
    else $error("serial or dma pin off its level");
  chk_halt_cause:
    assert property ($rose(rx_halted[0]) |-> $past(rx_in[0].valid, 2))
    else $error("halt without a received character");
  chk_flow_release:
    assert property ($fell(tx_flow[0].valid) |-> $past(tx_ready[0], 2))
    else $error("flow character dropped unaccepted");
  chk_flow_steady:
    assert property (tx_flow[0].valid && $past(tx_flow[0].valid) &&
      !$past(tx_ready[0], 2) |-> $stable(tx_flow[0].data))
    else $error("flow character changed while offered");
endmodule : qsf_monitor
bind qsf_top qsf_monitor #(.NUM_CHAN(NUM_CHAN)) u_mon (
  .mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_ready(tx_ready), .rx_in(rx_in),
  .tx_flow(tx_flow), .rx_halted(rx_halted), .serial_out(serial_out),
  .request_to_send_n(request_to_send_n),
  .terminal_ready_n(terminal_ready_n),
  .rx_dma_request_n(rx_dma_request_n),
  .tx_dma_request_n(tx_dma_request_n)
);
`default_nettype wire

//--- sim/qsf_remote.sv
// Model of the remote transceiver: takes flow characters, sends bytes.
// Assumes the bench reads the taken channel 0 characters from got.
`timescale 1ns/10ps
`default_nettype none
module qsf_remote #(
  parameter int NUM_CHAN = 4
) (
  input  wire logic                              mclk,
  input  wire logic                              slow,
  input  wire qsf_pkg::qsf_char_t [NUM_CHAN-1:0] tx_flow,
  output var logic [NUM_CHAN-1:0]                tx_ready,
  output var qsf_pkg::qsf_char_t [NUM_CHAN-1:0]  rx_in
);
  logic [1:0]          stall_cnt;
  logic [NUM_CHAN-1:0] ready_q;
  logic [7:0]          got [$];
  initial begin
    stall_cnt = 2'h0;
    ready_q = '0;
    tx_ready = '0;
    rx_in = '0;
  end
  // Only channel 0 is logged, which keeps the model small.
  always @(posedge mclk) begin
    stall_cnt <= stall_cnt + 2'h1;
    tx_ready <= {NUM_CHAN{!slow || stall_cnt == 2'h3}};
    ready_q <= tx_ready;
    if (tx_flow[0].valid && ready_q[0])
      got.push_back(tx_flow[0].data);
  end
  task automatic send_char(input int ch, input logic [7:0] b);
    @(posedge mclk);
    rx_in[ch] <= '{valid: 1'h1, data: b};
    @(posedge mclk);
    rx_in[ch] <= '{valid: 1'h0, data: ~b};
  endtask : send_char
endmodule : qsf_remote
`default_nettype wire

//--- sim/qsf_tb_top.sv
// Self-checking bench for the quad soft-flow block over APB.
// Assumes the remote model on the far side of every channel.
`timescale 1ns/10ps
`default_nettype none
module qsf_tb_top;
  typedef struct packed {
    logic [5:0] off;
    logic       we;
    logic [7:0] wd;
    logic [7:0] exp;
    logic       err;
  } qsf_row_t;
  logic                     mclk, rst_n, psel, penable, pwrite, err;
  logic                     pready, pslverr, slow;
  logic                     rx_dma_request_n, tx_dma_request_n;
  logic [7:0]               paddr;
  logic [31:0]              pwdata, prdata, rd;
  logic [3:0][3:0]          modem_in;
  logic [3:0]               tx_ready, rx_halted, serial_out;
  logic [3:0]               request_to_send_n, terminal_ready_n;
  qsf_pkg::qsf_char_t [3:0] rx_in, tx_flow;
  logic [7:0]               fc [4] = '{8'h13, 8'h93, 8'h11, 8'h91};
  logic [3:0]               mpin [4] = '{4'h1, 4'h2, 4'h8, 4'h9};
  int                       failures, n_tests, k, n;
  qsf_row_t rows [16] = '{
    '{6'h00, 1'h0, 8'h0, 8'h00, 1'h0}, '{6'h04, 1'h0, 8'h0, 8'h01, 1'h0},
    '{6'h08, 1'h0, 8'h0, 8'h00, 1'h0}, '{6'h0C, 1'h0, 8'h0, 8'h00, 1'h0},
    '{6'h10, 1'h0, 8'h0, 8'h60, 1'h0}, '{6'h14, 1'h0, 8'h0, 8'h00, 1'h0},
    '{6'h18, 1'h0, 8'h0, 8'h00, 1'h0}, '{6'h1C, 1'h0, 8'h0, 8'h00, 1'h0},
    '{6'h04, 1'h1, 8'hFF, 8'h0, 1'h0}, '{6'h04, 1'h0, 8'h0, 8'h01, 1'h0},
    '{6'h10, 1'h1, 8'h00, 8'h0, 1'h0}, '{6'h10, 1'h0, 8'h0, 8'h60, 1'h0},
    '{6'h0C, 1'h1, 8'h03, 8'h0, 1'h0}, '{6'h0C, 1'h0, 8'h0, 8'h03, 1'h0},
    '{6'h34, 1'h0, 8'h0, 8'h00, 1'h1}, '{6'h01, 1'h0, 8'h0, 8'h00, 1'h1}};
  qsf_top #(.NUM_CHAN(4)) DUT (
    .mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .modem_in(modem_in),
    .rx_in(rx_in), .tx_ready(tx_ready), .tx_flow(tx_flow),
    .rx_halted(rx_halted), .serial_out(serial_out),
    .request_to_send_n(request_to_send_n),
    .terminal_ready_n(terminal_ready_n),
    .rx_dma_request_n(rx_dma_request_n),
    .tx_dma_request_n(tx_dma_request_n));
  qsf_remote #(.NUM_CHAN(4)) u_remote (
    .mclk(mclk), .slow(slow), .tx_flow(tx_flow), .tx_ready(tx_ready),
    .rx_in(rx_in));
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic print_verdict;
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // Each call first lets an edge pass, so strobes never toggle twice.
  task automatic apb(input logic [7:0] a, input logic we,
                     input logic [7:0] wd);
    @(posedge mclk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= we;
    pwdata <= {24'h0, wd};
    @(posedge mclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (pready !== 1'h1) begin
      failures++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wait_got(input int want);
    k = 0;
    while (u_remote.got.size() < want && k < 60) begin
      @(posedge mclk);
      k++;
    end
    repeat (6) @(posedge mclk);
    check(u_remote.got.size(), want);
  endtask : wait_got
  task automatic rx_step(input logic [7:0] a, input logic [7:0] b,
                         input logic two, input logic exp);
    u_remote.send_char(0, a);
    if (two)
      u_remote.send_char(0, b);
    repeat (2) @(posedge mclk);
    #1;
    check(rx_halted[0], exp);
  endtask : rx_step
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {rst_n, psel, penable, pwrite, slow, paddr, pwdata} = '0;
    modem_in = '0;
    failures = 0;
    n_tests = 0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'h1;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 16; r++) begin
        apb({c[1:0], rows[r].off}, rows[r].we, rows[r].wd);
        if (rows[r].we)
          check(err, rows[r].err);
        else
          check({err, rd}, {rows[r].err, 24'h0, rows[r].exp});
      end
    end
    check({request_to_send_n, terminal_ready_n}, 8'h00);
    apb(8'h4C, 1'h1, 8'h00);
    repeat (2) @(posedge mclk);
    check({request_to_send_n, terminal_ready_n}, 8'h22);
    modem_in <= {mpin[3], mpin[2], mpin[1], mpin[0]};
    repeat (3) @(posedge mclk);
    for (int c = 0; c < 4; c++) begin
      apb({c[1:0], 6'h14}, 1'h0, 8'h00);
      check(rd, {mpin[c], mpin[c]});
      apb({c[1:0], 6'h14}, 1'h0, 8'h00);
      check(rd, {mpin[c], 4'h0});
    end
    for (int i = 0; i < 4; i++)
      apb({2'h0, 4'h8 + 4'(i), 2'h0}, 1'h1, fc[i]);
    // The both-pairs case runs with the remote stalling.
    for (int t = 0; t < 4; t++) begin
      slow <= (t == 3);
      apb(8'h1C, 1'h1, {4'h0, t[1:0], 2'h0});
      for (int cmd = 1; cmd < 3; cmd++) begin
        u_remote.got.delete();
        n = (t == 3) ? 2 : ((t == 0) ? 0 : 1);
        apb(8'h30, 1'h1, cmd[7:0]);
        wait_got(n);
        if (n > 0)
          check(u_remote.got[0], fc[2 * cmd - 2 + (t == 1)]);
        if (n > 1)
          check(u_remote.got[1], fc[2 * cmd - 1]);
      end
    end
    for (int m = 1; m < 4; m++) begin
      apb(8'h1C, 1'h1, m[7:0]);
      rx_step(fc[(m == 1) ? 0 : 1], 8'h41, 1'h0, 1'h0);
      rx_step(fc[m == 1], fc[1], m == 3, 1'h1);
      rx_step(fc[(m == 1) ? 2 : 3], 8'h41, 1'h0, 1'h1);
      rx_step(fc[2 + (m == 1)], fc[3], m == 3, 1'h0);
    end
    rx_step(fc[0], fc[1], 1'h1, 1'h1);
    @(posedge mclk);
    rst_n <= 1'h0;
    @(posedge mclk);
    #1;
    check({serial_out, request_to_send_n, terminal_ready_n, rx_halted,
           rx_dma_request_n, tx_dma_request_n}, {12'hFFF, 4'h0, 2'h2});
    @(posedge mclk);
    rst_n <= 1'h1;
    for (int c = 0; c < 4; c++) begin
      apb({c[1:0], 6'h1C}, 1'h0, 8'h00);
      check(rd, 32'h0);
      apb({c[1:0], 6'h0C}, 1'h0, 8'h00);
      check(rd, 32'h0);
    end
    print_verdict();
  end
endmodule : qsf_tb_top
`default_nettype wire
